// >>> common/board_map_pkg.sv
// shared constants and types for the board memory map decoder
package board_map_pkg;

    // ------------------------------------------------------------
    // synchroniser layout
    // ------------------------------------------------------------
    localparam int SYNC_W    = 11;
    localparam int IX_SWITCH = 0;
    localparam int IX_INTERP = 1;
    localparam int IX_SPLIT  = 2;
    localparam int IX_OVLP   = 3;
    localparam int IX_TYPE_A = 4;
    localparam int IX_TYPE_B = 5;
    localparam int IX_EXTF   = 6;
    localparam int IX_BUTTON = 7;
    localparam int IX_PROGRAM_READ_STROBE_N_N = 8;
    localparam int IX_RD_N   = 9;
    localparam int IX_WR_N   = 10;
    // strobes idle high, jumpers and switch idle low
    localparam logic [SYNC_W-1:0] SYNC_RESET = 11'h700;

    // ------------------------------------------------------------
    // reset values and levels
    // ------------------------------------------------------------
    localparam logic CS_IDLE       = 1'b1;
    localparam logic STROBE_IDLE   = 1'b1;
    localparam logic LED_OFF       = 1'b0;
    localparam logic RAM_CODE_BANK = 1'b0;
    localparam logic RAM_DATA_BANK = 1'b1;
    localparam logic MAP_BOOT_LOW  = 1'b0;
    localparam logic MAP_RAM_LOW   = 1'b1;

    // settle count at which ST_SETTLE ends, four cycles after rst, so the synchronisers have settled
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_MONITOR       = 2'b00,
        MODE_SPLIT         = 2'b01,
        MODE_SPLIT_OVERLAP = 2'b10,
        MODE_INTERP        = 2'b11
    } mode_e;

    typedef enum logic [1:0] {
        ST_SETTLE = 2'b00,
        ST_HELD   = 2'b01,
        ST_RUN    = 2'b10
    } board_state_e;

endpackage

// >>> verilog/pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync
    import board_map_pkg::*;
#(
    parameter int               WIDTH       = SYNC_W,
    parameter logic [WIDTH-1:0] RESET_VALUE = SYNC_RESET
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // ------------------------------------------------------------
    // capture chain; stage1 feeds only stage2
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stage1 <= RESET_VALUE;
            stage2 <= RESET_VALUE;
            stage3 <= RESET_VALUE;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // ------------------------------------------------------------
    // a bit moves only once stage2 and stage3 agree
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pin_out[i] <= RESET_VALUE[i];
                end else if (stage2[i] == stage3[i]) begin
                    pin_out[i] <= stage3[i];
                end
            end
        end
    endgenerate

endmodule

// >>> verilog/board_memory_map_decoder.sv
// memory socket decoder, mode indicators and board reset for the controller card
`timescale 1ns/1ns
module board_memory_map_decoder
    import board_map_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic map_switch_swapped,
    input  wire logic interp_jumper,
    input  wire logic split_bank_mode_jumper,
    input  wire logic bank_overlap_jumper,
    input  wire logic boot_type_jumper_a,
    input  wire logic boot_type_jumper_b,
    input  wire logic external_fetch_jumper,
    input  wire logic reset_button,
    input  wire logic program_read_strobe_n,
    input  wire logic data_read_strobe_n,
    input  wire logic data_write_strobe_n,
    input  wire logic addr_high,
    output logic      boot_memory_socket_cs_n,
    output logic      ram_socket_cs_n,
    output logic      ram_bank_high,
    output logic      mem_read_n,
    output logic      ram_write_n,
    output logic      boot_write_n,
    output logic      led_red,
    output logic      led_green,
    output logic      external_fetch_select_n,
    output logic      proc_reset,
    output logic      boot_type_fault
);

    // ------------------------------------------------------------
    // pin synchronisation
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] pins;
    logic [2:0]        addr_stage;
    logic              addr_s;

    assign pins_raw = {data_write_strobe_n, data_read_strobe_n, program_read_strobe_n, reset_button,
                       external_fetch_jumper, boot_type_jumper_b, boot_type_jumper_a, bank_overlap_jumper,
                       split_bank_mode_jumper, interp_jumper, map_switch_swapped};

    pin_sync #(
        .WIDTH       (SYNC_W),
        .RESET_VALUE (SYNC_RESET)
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin_in  (pins_raw),
        .pin_out (pins)
    );

    // address pin takes the same three-stage agreement filter as the strobes, so it never lags them
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            addr_stage <= 3'h0;
            addr_s     <= 1'b0;
        end else begin
            addr_stage <= {addr_stage[1:0], addr_high};
            if (addr_stage[1] == addr_stage[2]) begin
                addr_s <= addr_stage[2];
            end
        end
    end

    logic program_read_strobe_n_s;
    logic rd_s;
    logic wr_s;
    assign program_read_strobe_n_s = ~pins[IX_PROGRAM_READ_STROBE_N_N];
    assign rd_s   = ~pins[IX_RD_N];
    assign wr_s   = ~pins[IX_WR_N];

    // ------------------------------------------------------------
    // decode functions
    // ------------------------------------------------------------
    function automatic mode_e decode_mode(input logic interp, input logic split, input logic ovlp);
        if (interp) begin
            decode_mode = MODE_INTERP;
        end else if (split && ovlp) begin
            decode_mode = MODE_SPLIT_OVERLAP;
        end else if (split) begin
            decode_mode = MODE_SPLIT;
        end else begin
            decode_mode = MODE_MONITOR;
        end
    endfunction

    // true when the access falls on the boot socket
    function automatic logic boot_hit(input logic ram_low, input logic upper_half);
        boot_hit = (ram_low == MAP_RAM_LOW) ? upper_half : ~upper_half;
    endfunction

    // ------------------------------------------------------------
    // board reset sequencing
    // ------------------------------------------------------------
    board_state_e state;
    logic [1:0]   settle_count;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state        <= ST_SETTLE;
            settle_count <= 2'h0;
        end else begin
            case (state)
                ST_SETTLE: begin
                    settle_count <= settle_count + 2'h1;
                    if (settle_count == SETTLE_CYCLES) begin
                        state <= ST_HELD;
                    end
                end
                ST_HELD: begin
                    if (!pins[IX_BUTTON]) begin
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (pins[IX_BUTTON]) begin
                        state <= ST_HELD;
                    end
                end
                default: begin
                    state <= ST_SETTLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // map and mode, frozen while the program runs
    // ------------------------------------------------------------
    mode_e mode;
    logic  map_ram_low;

    // a switch moved during execution is ignored until the next reset, so code never sees a swap
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode        <= MODE_MONITOR;
            map_ram_low <= MAP_BOOT_LOW;
        end else if (state != ST_RUN) begin
            mode <= decode_mode(pins[IX_INTERP], pins[IX_SPLIT], pins[IX_OVLP]);
            if (pins[IX_INTERP]) begin
                map_ram_low <= MAP_RAM_LOW;
            end else begin
                map_ram_low <= pins[IX_SWITCH];
            end
        end
    end

    // ------------------------------------------------------------
    // socket decode
    // ------------------------------------------------------------
    logic next_boot_cs_n;
    logic next_ram_cs_n;
    logic next_bank;
    logic next_read_n;
    logic hit_boot;
    logic boot_is_ram;

    assign hit_boot    = boot_hit(map_ram_low, addr_s);
    assign boot_is_ram = pins[IX_TYPE_A] & pins[IX_TYPE_B];

    always_comb begin
        next_boot_cs_n = CS_IDLE;
        next_ram_cs_n  = CS_IDLE;
        next_bank      = RAM_CODE_BANK;
        next_read_n    = STROBE_IDLE;
        if (state == ST_RUN) begin
            // read enable is the AND of the two active-low strobes
            next_read_n = pins[IX_PROGRAM_READ_STROBE_N_N] & pins[IX_RD_N];
            if (mode == MODE_SPLIT) begin
                // code space follows the map; data space is the whole upper RAM bank
                next_boot_cs_n = ~(program_read_strobe_n_s & hit_boot);
                next_ram_cs_n  = ~((program_read_strobe_n_s & ~hit_boot) | rd_s | wr_s);
                next_bank      = (rd_s | wr_s) ? RAM_DATA_BANK : RAM_CODE_BANK;
            end else begin
                // one 64K image seen by both code and data accesses
                next_boot_cs_n = ~((program_read_strobe_n_s | rd_s | wr_s) & hit_boot);
                next_ram_cs_n  = ~((program_read_strobe_n_s | rd_s | wr_s) & ~hit_boot);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            boot_memory_socket_cs_n <= CS_IDLE;
            ram_socket_cs_n         <= CS_IDLE;
            ram_bank_high           <= RAM_CODE_BANK;
            mem_read_n              <= STROBE_IDLE;
        end else begin
            boot_memory_socket_cs_n <= next_boot_cs_n;
            ram_socket_cs_n         <= next_ram_cs_n;
            ram_bank_high           <= next_bank;
            mem_read_n              <= next_read_n;
        end
    end

    // ------------------------------------------------------------
    // write enables
    // ------------------------------------------------------------
    // an EPROM in the boot socket must never see a write pulse; mismatched jumpers count as EPROM
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ram_write_n     <= STROBE_IDLE;
            boot_write_n    <= STROBE_IDLE;
            boot_type_fault <= 1'b0;
        end else begin
            ram_write_n     <= ~(wr_s && state == ST_RUN);
            boot_write_n    <= ~(wr_s && state == ST_RUN && boot_is_ram);
            boot_type_fault <= pins[IX_TYPE_A] ^ pins[IX_TYPE_B];
        end
    end

    // ------------------------------------------------------------
    // indicators, fetch select and processor reset
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            led_red                 <= LED_OFF;
            led_green               <= LED_OFF;
            external_fetch_select_n <= 1'b1;
            proc_reset              <= 1'b1;
        end else begin
            led_red                 <= (mode == MODE_INTERP) | (map_ram_low == MAP_BOOT_LOW);
            led_green               <= (mode == MODE_INTERP) | (map_ram_low == MAP_RAM_LOW);
            external_fetch_select_n <= ~pins[IX_EXTF];
            proc_reset              <= (state != ST_RUN);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_boot_low_map: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_RUN && mode == MODE_MONITOR && map_ram_low == MAP_BOOT_LOW && program_read_strobe_n_s && !addr_s)
        |=> (!boot_memory_socket_cs_n && ram_socket_cs_n))
        else $error("boot position low fetch did not select boot socket");

    a_swapped_map: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_RUN && mode == MODE_MONITOR && map_ram_low == MAP_RAM_LOW && rd_s && !addr_s)
        |=> (!ram_socket_cs_n && boot_memory_socket_cs_n))
        else $error("swapped position low read did not select RAM socket");

    a_upper_half: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_RUN && mode == MODE_MONITOR && map_ram_low == MAP_BOOT_LOW && rd_s && addr_s)
        |=> (!ram_socket_cs_n && boot_memory_socket_cs_n))
        else $error("upper half in boot position did not select RAM socket");

    a_led_pair: assert property (
        @(posedge sys_clk) disable iff (rst)
        (mode != MODE_INTERP) |=> (led_red != led_green) && (led_green == $past(map_ram_low)))
        else $error("indicators do not follow the map position");

    a_interp_leds: assert property (
        @(posedge sys_clk) disable iff (rst)
        (mode == MODE_INTERP) [*2] |=> (led_red && led_green))
        else $error("interpreter mode did not light both indicators");

    a_interp_map: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_HELD && pins[IX_INTERP]) |=> (map_ram_low == MAP_RAM_LOW && mode == MODE_INTERP))
        else $error("switch not ignored under interpreter jumper");

    a_fetch_select: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(pins[IX_EXTF]) |=> !external_fetch_select_n)
        else $error("external fetch select not driven low with jumper");

    a_boot_write: assert property (
        @(posedge sys_clk) disable iff (rst)
        !boot_write_n |-> ($past(boot_is_ram) && !ram_write_n && !boot_type_fault))
        else $error("boot socket written without RAM type selection");

    a_shared_read: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_RUN && (program_read_strobe_n_s || rd_s)) |=> !mem_read_n)
        else $error("shared read enable missing for a strobe");

    a_split_data: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_RUN && mode == MODE_SPLIT && (rd_s || wr_s) && !program_read_strobe_n_s)
        |=> (ram_bank_high && !ram_socket_cs_n && boot_memory_socket_cs_n))
        else $error("split mode data access not routed to data bank");

    a_overlap_again: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_RUN && mode == MODE_SPLIT_OVERLAP && rd_s) |=> !ram_bank_high)
        else $error("overlap jumper did not restore shared banks");

    a_reset_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        (state == ST_RUN && pins[IX_BUTTON]) |=> ##1 proc_reset [*2])
        else $error("button press did not hold processor reset");

    c_swap_run:   cover property (@(posedge sys_clk) disable iff (rst) state == ST_RUN && map_ram_low == MAP_RAM_LOW);
    c_split_data: cover property (@(posedge sys_clk) disable iff (rst) ram_bank_high && !ram_socket_cs_n);
    c_interp:     cover property (@(posedge sys_clk) disable iff (rst) led_red && led_green);
    c_boot_write: cover property (@(posedge sys_clk) disable iff (rst) !boot_write_n);

endmodule

// >>> verif/socket_pair_model.sv
// behavioural model of the boot socket and the ram socket on the card bus
`timescale 1ns/1ns
module socket_pair_model
    import board_map_pkg::*;
(
    input  wire logic       boot_cs_n,
    input  wire logic       ram_cs_n,
    input  wire logic       bank_high,
    input  wire logic       read_n,
    input  wire logic       ram_wr_n,
    input  wire logic       boot_wr_n,
    input  wire logic       boot_fitted_ram,
    output logic      [1:0] read_hit,
    output logic      [1:0] write_hit,
    output logic            clash,
    output logic            bad_write
);
    // ------------------------------------------------------------
    // which socket answers: 1 boot, 2 ram code bank, 3 ram data bank
    // ------------------------------------------------------------
    always_comb begin
        read_hit = 2'h0;
        if (!read_n && !boot_cs_n) begin
            read_hit = 2'h1;
        end else if (!read_n && !ram_cs_n) begin
            read_hit = bank_high ? 2'h3 : 2'h2;
        end
    end

    // an eprom ignores write strobes, so a write there is only flagged
    always_comb begin
        write_hit = 2'h0;
        if (!boot_wr_n && !boot_cs_n && boot_fitted_ram) begin
            write_hit = 2'h1;
        end else if (!ram_wr_n && !ram_cs_n) begin
            write_hit = bank_high ? 2'h3 : 2'h2;
        end
    end

    assign clash     = !boot_cs_n && !ram_cs_n;
    assign bad_write = !boot_wr_n && !boot_cs_n && !boot_fitted_ram;
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the board memory map decoder
`timescale 1ns/1ns
module tb_top
    import board_map_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic       map_switch_swapped = 1'b0;
    logic       interp_jumper = 1'b0;
    logic       split_bank_mode_jumper = 1'b0;
    logic       bank_overlap_jumper = 1'b0;
    logic       boot_type_jumper_a = 1'b0;
    logic       boot_type_jumper_b = 1'b0;
    logic       external_fetch_jumper = 1'b0;
    logic       reset_button = 1'b0;
    logic       program_read_strobe_n = 1'b1;
    logic       data_read_strobe_n = 1'b1;
    logic       data_write_strobe_n = 1'b1;
    logic       addr_high = 1'b0;
    logic       boot_memory_socket_cs_n, ram_socket_cs_n, ram_bank_high, mem_read_n;
    logic       ram_write_n, boot_write_n, led_red, led_green;
    logic       external_fetch_select_n, proc_reset, boot_type_fault;
    logic [1:0] read_hit, write_hit;
    logic       clash, bad_write;
    int         fail_count = 0;
    int         num_checks = 0;
    // bits: 0 swapped, 1 interp, 2 split, 3 overlap, 4 type a, 5 type b
    logic [5:0] cfg_tab [9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h35, 6'h3c, 6'h10, 6'h31};

    always #10 sys_clk = ~sys_clk;

    board_memory_map_decoder board_memory_map_decoder_i (
        .sys_clk(sys_clk), .rst(rst), .map_switch_swapped(map_switch_swapped),
        .interp_jumper(interp_jumper), .split_bank_mode_jumper(split_bank_mode_jumper),
        .bank_overlap_jumper(bank_overlap_jumper), .boot_type_jumper_a(boot_type_jumper_a),
        .boot_type_jumper_b(boot_type_jumper_b), .external_fetch_jumper(external_fetch_jumper),
        .reset_button(reset_button), .program_read_strobe_n(program_read_strobe_n),
        .data_read_strobe_n(data_read_strobe_n), .data_write_strobe_n(data_write_strobe_n),
        .addr_high(addr_high), .boot_memory_socket_cs_n(boot_memory_socket_cs_n),
        .ram_socket_cs_n(ram_socket_cs_n), .ram_bank_high(ram_bank_high), .mem_read_n(mem_read_n),
        .ram_write_n(ram_write_n), .boot_write_n(boot_write_n), .led_red(led_red),
        .led_green(led_green), .external_fetch_select_n(external_fetch_select_n),
        .proc_reset(proc_reset), .boot_type_fault(boot_type_fault)
    );

    socket_pair_model socket_pair_model_i (
        .boot_cs_n(boot_memory_socket_cs_n), .ram_cs_n(ram_socket_cs_n), .bank_high(ram_bank_high),
        .read_n(mem_read_n), .ram_wr_n(ram_write_n), .boot_wr_n(boot_write_n),
        .boot_fitted_ram(boot_type_jumper_a & boot_type_jumper_b), .read_hit(read_hit),
        .write_hit(write_hit), .clash(clash), .bad_write(bad_write)
    );

    // ------------------------------------------------------------
    // compare tasks and expectations
    // ------------------------------------------------------------
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t bit got %b exp %b", $time, got, exp);
        end
    endtask

    task automatic chk_code(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t socket code got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic [1:0] exp_hit(input logic [5:0] c, input int k, input logic ah, input logic wr);
        logic ram_low;
        logic split;
        ram_low = c[1] | c[0];
        split = c[2] & ~c[3] & ~c[1];
        if (wr != (k == 2)) return 2'h0;
        if (split && k != 0) return 2'h3;
        if (ah != ram_low) return 2'h2;
        if (wr) return (c[4] & c[5]) ? 2'h1 : 2'h0;
        return 2'h1;
    endfunction

    // ------------------------------------------------------------
    // stimulus tasks
    // ------------------------------------------------------------
    // map and jumpers are moved only while the button is held
    task automatic set_cfg(input logic [5:0] c, input logic ef);
        int n;
        @(negedge sys_clk);
        reset_button = 1'b1;
        repeat (6) @(negedge sys_clk);
        chk_bit(proc_reset, 1'b1);
        chk_bit(boot_memory_socket_cs_n, CS_IDLE);
        map_switch_swapped = c[0];
        interp_jumper = c[1];
        split_bank_mode_jumper = c[2];
        bank_overlap_jumper = c[3];
        boot_type_jumper_a = c[4];
        boot_type_jumper_b = c[5];
        external_fetch_jumper = ef;
        repeat (8) @(negedge sys_clk);
        reset_button = 1'b0;
        n = 0;
        while (proc_reset !== 1'b0 && n < 20) begin
            @(negedge sys_clk);
            n++;
        end
        chk_bit(proc_reset, 1'b0);
    endtask

    // address settles a cycle before the strobe so it is synced a cycle ahead of it
    task automatic access(input int k, input logic ah, input logic [1:0] er, input logic [1:0] ew);
        @(negedge sys_clk);
        addr_high = ah;
        @(negedge sys_clk);
        program_read_strobe_n = (k != 0);
        data_read_strobe_n = (k != 1);
        data_write_strobe_n = (k != 2);
        repeat (6) @(negedge sys_clk);
        chk_code(read_hit, er);
        chk_code(write_hit, ew);
        chk_bit(mem_read_n, k == 2);
        chk_bit(clash, 1'b0);
        chk_bit(bad_write, 1'b0);
        program_read_strobe_n = STROBE_IDLE;
        data_read_strobe_n = STROBE_IDLE;
        data_write_strobe_n = STROBE_IDLE;
        repeat (6) @(negedge sys_clk);
        chk_code(read_hit, 2'h0);
        chk_code(write_hit, 2'h0);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(negedge sys_clk);
        chk_bit(proc_reset, 1'b1);
        chk_bit(ram_socket_cs_n, CS_IDLE);
        rst = 1'b0;
        for (int i = 0; i < 9; i++) begin
            set_cfg(cfg_tab[i], i[0]);
            for (int a = 0; a < 2; a++) begin
                for (int k = 0; k < 3; k++) begin
                    access(k, a[0], exp_hit(cfg_tab[i], k, a[0], 1'b0), exp_hit(cfg_tab[i], k, a[0], 1'b1));
                end
            end
            chk_bit(led_red, cfg_tab[i][1] | ~cfg_tab[i][0]);
            chk_bit(led_green, cfg_tab[i][1] | cfg_tab[i][0]);
            chk_bit(external_fetch_select_n, ~i[0]);
            chk_bit(boot_type_fault, cfg_tab[i][4] ^ cfg_tab[i][5]);
            $display("test %0d done", i);
        end
        // switch flipped while running must not swap the map
        set_cfg(6'h00, 1'b1);
        @(negedge sys_clk);
        map_switch_swapped = 1'b1;
        repeat (8) @(negedge sys_clk);
        access(0, 1'b0, 2'h1, 2'h0);
        chk_bit(led_red, 1'b1);
        $display("test run lock done");
        stop_test();
    end

    // whole run is near 1000 cycles; the limit leaves ample margin
    initial begin
        #200000;
        fail_count++;
        $display("[ERR] t=%0t watchdog expired", $time);
        stop_test();
    end
endmodule
